// File: shared/cfdf_pkg.sv
// Package for the CAN FD error diagnostic and acceptance filter block
package cfdf_pkg;
    // Build figures
    localparam int NUM_FILTERS = 16;
    localparam int NUM_FLTCON = NUM_FILTERS / 4;
    localparam int FLTCON_IDX_W = 2;
    localparam int FLT_IDX_W = 4;
    localparam int OBJ_PTR_W = 5;
    localparam int ERR_FREE_CNT_W = 16;
    localparam int RECOVERY_RUN_BITS = 11;
    localparam int STUFF_LIMIT = 5;
    localparam int ADDR_W = 8;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] DIAG_OFFS = 8'h00;
    localparam logic [ADDR_W-1:0] HIT_STATUS_OFFS = 8'h04;
    localparam logic [ADDR_W-1:0] MODE_CTRL_OFFS = 8'h08;
    localparam logic [ADDR_W-1:0] FLTCON_BASE = 8'h10;
    localparam logic [ADDR_W-1:0] FLTOBJ_BASE = 8'h40;
    localparam logic [ADDR_W-1:0] MASK_BASE = 8'h80;

    // Diagnostic flag bit positions
    localparam int DIAG_LEN_MISMATCH = 31;
    localparam int DIAG_ESI = 30;
    localparam int DIAG_D_CRC = 29;
    localparam int DIAG_D_STUFF = 28;
    localparam int DIAG_D_FORM = 27;
    localparam int DIAG_D_BIT1 = 25;
    localparam int DIAG_D_BIT0 = 24;
    localparam int DIAG_BUS_OFF = 23;
    localparam int DIAG_N_CRC = 21;
    localparam int DIAG_N_STUFF = 20;
    localparam int DIAG_N_FORM = 19;
    localparam int DIAG_N_ACK = 18;
    localparam int DIAG_N_BIT1 = 17;
    localparam int DIAG_N_BIT0 = 16;
    localparam logic [31:0] DIAG_FLAG_MASK = 32'hfbbf0000;
    localparam logic [31:0] DIAG_RESET = 32'h00000000;

    // Filter control field layout, one byte per filter
    localparam int FLTCON_EN_BIT = 7;
    localparam logic [7:0] FLTCON_BYTE_MASK = 8'h9f;

    // Filter object / mask field layout
    localparam int OBJ_EXT_SEL_BIT = 30;
    localparam int OBJ_SID_X_BIT = 29;
    localparam int OBJ_EID_LSB = 11;
    localparam int OBJ_EID_MSB = 28;
    localparam int OBJ_SID_MSB = 10;
    localparam logic [31:0] OBJ_MASK = 32'h7fffffff;
    localparam int MODE_DNET_BIT = 0;

    // Error event kinds reported by the protocol engine
    typedef enum logic [2:0] {
        CFDF_ERR_CRC, CFDF_ERR_STUFF, CFDF_ERR_FORM, CFDF_ERR_ACK,
        CFDF_ERR_BIT1, CFDF_ERR_BIT0
    } cfdf_err_kind_t;

    // One error report from the bit stream engine
    typedef struct packed {
        logic valid;
        cfdf_err_kind_t kind;
        logic data_rate;
        logic [5:0] run_len;
    } cfdf_err_evt_t;

    // Frame descriptor presented for acceptance filtering
    typedef struct packed {
        logic valid;
        logic ext;
        logic [10:0] standard_id_pattern;
        logic sid_x;
        logic [17:0] extended_id_pattern;
        logic [15:0] data01;
    } cfdf_frame_t;
endpackage

// File: src/cfdf_diag_filter.sv
// CAN FD error diagnostic flags and receive acceptance filters
`timescale 1ns/1ps
// What this block does
// R01: Flag DLC larger than element payload size
// R02: Flag received FD frame with ESI set
// R03: Flag data-phase CRC mismatch
// R04: Flag nominal-phase CRC mismatch
// R05: Flag stuff error beyond five equal bits
// R06: Flag form error in fixed fields
// R07: Flag recessive sent but dominant seen
// R08: Flag dominant sent but recessive seen
// R09: Recovery: eleven recessive bits set dominant flag
// R10: Flag bus-off entry with auto recovery
// R11: Flag transmitted frame not acknowledged
// R12: Nominal-rate errors go to nominal flags
// R13: Data-rate errors other than ack go to data flags
// R14: Sixteen-bit error-free frame counter, low half
// R15: Four filters per control register, enable bits
// R16: Five-bit pointer selects receive object
// R17: Software never programs pointer zero
// R18: Software edits filter only while disabled
// R19: Control register count is filters over four
// R20: Type match: extended bit selects frame kind
// R21: Object holds STANDARD_ID_PATTERN, extra bit, EXTENDED_ID_PATTERN pattern
// R22: Alternate mode compares EXTENDED_ID_PATTERN to data bytes
// R23: Type match off accepts either frame kind
// R24: Only mask-one bits are compared
module cfdf_diag_filter
    import cfdf_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] AWADDR_IN,
    input wire logic AWVALID_IN,
    output logic AWREADY_OUT,
    input wire logic [31:0] WDATA_IN,
    input wire logic [3:0] WSTRB_IN,
    input wire logic WVALID_IN,
    output logic WREADY_OUT,
    output logic [1:0] BRESP_OUT,
    output logic BVALID_OUT,
    input wire logic BREADY_IN,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] ARADDR_IN,
    input wire logic ARVALID_IN,
    output logic ARREADY_OUT,
    output logic [31:0] RDATA_OUT,
    output logic [1:0] RRESP_OUT,
    output logic RVALID_OUT,
    input wire logic RREADY_IN,
    // Protocol engine events
    input wire cfdf_err_evt_t ERR_EVT_IN,
    input wire logic FRAME_OK_IN,
    input wire logic FRAME_DONE_IN,
    input wire logic [6:0] FRAME_DLC_BYTES_IN,
    input wire logic [6:0] PAYLOAD_SIZE_IN,
    input wire logic FD_FRAME_IN,
    input wire logic ESI_BIT_IN,
    input wire logic BUS_OFF_RECOVERED_IN,
    input wire logic RECOVERY_ACTIVE_IN,
    // Acceptance filter request and answer
    input wire cfdf_frame_t FRAME_IN,
    output logic HIT_VALID_OUT,
    output logic HIT_OUT,
    output logic [OBJ_PTR_W-1:0] HIT_OBJECT_OUT,
    output logic [FLT_IDX_W-1:0] HIT_FILTER_OUT
);

    // Register storage
    logic [31:0] diag_r;
    logic [7:0] fltcon_r [NUM_FILTERS];
    logic [31:0] fltobj_r [NUM_FILTERS];
    logic [31:0] mask_r [NUM_FILTERS];
    logic mode_dnet_r;
    logic [31:0] hit_status_r;

    // Bus slave state
    logic aw_held_r;
    logic w_held_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic wr_go;
    logic wr_ok;
    logic rd_ok;
    logic [31:0] rd_val;

    // Byte-lane merge used by the diagnostic, filter object and mask registers
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Decode an address into a register bank index, or report a miss
    function automatic logic bank_hit(input logic [ADDR_W-1:0] addr,
                                      input logic [ADDR_W-1:0] base,
                                      input int count);
        return (addr >= base) && (addr < base + ADDR_W'(count * 4))
            && (addr[1:0] == 2'b00);
    endfunction

    function automatic logic [FLT_IDX_W-1:0] bank_idx(input logic [ADDR_W-1:0] addr,
                                                      input logic [ADDR_W-1:0] base);
        logic [ADDR_W-1:0] diff;
        diff = addr - base;
        return diff[FLT_IDX_W+1:2];
    endfunction

    // Flat filter slot of byte lane k in a control register
    function automatic logic [FLT_IDX_W-1:0] con_slot(input logic [ADDR_W-1:0] addr,
                                                      input int k);
        logic [FLT_IDX_W-1:0] row;
        row = bank_idx(addr, FLTCON_BASE);
        return {row[FLTCON_IDX_W-1:0], 2'(k)};
    endfunction

    // Write channel handshakes: address and data taken in either order
    assign AWREADY_OUT = !aw_held_r && !BVALID_OUT;
    assign WREADY_OUT = !w_held_r && !BVALID_OUT;
    assign ARREADY_OUT = !RVALID_OUT;
    assign wr_go = aw_held_r && w_held_r && !BVALID_OUT;

    // Capture write address and data
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else begin
            if (AWVALID_IN && AWREADY_OUT) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= AWADDR_IN;
            end else if (wr_go) begin
                aw_held_r <= 1'b0;
            end
            if (WVALID_IN && WREADY_OUT) begin
                w_held_r <= 1'b1;
                w_data_r <= WDATA_IN;
                w_strb_r <= WSTRB_IN;
            end else if (wr_go) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Address check for writes; unmapped addresses answer SLVERR
    always_comb begin
        wr_ok = (aw_addr_r == DIAG_OFFS) || (aw_addr_r == MODE_CTRL_OFFS)
            || (aw_addr_r == HIT_STATUS_OFFS)
            || bank_hit(aw_addr_r, FLTCON_BASE, NUM_FLTCON) // see R19
            || bank_hit(aw_addr_r, FLTOBJ_BASE, NUM_FILTERS)
            || bank_hit(aw_addr_r, MASK_BASE, NUM_FILTERS);
    end

    // Write response
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            BVALID_OUT <= 1'b0;
            BRESP_OUT <= 2'b00;
        end else if (wr_go) begin
            BVALID_OUT <= 1'b1;
            BRESP_OUT <= wr_ok ? 2'b00 : 2'b10;
        end else if (BREADY_IN) begin
            BVALID_OUT <= 1'b0;
        end
    end

    // Read decode
    always_comb begin
        rd_val = 32'h00000000;
        rd_ok = 1'b1;
        if (ARADDR_IN == DIAG_OFFS) begin
            rd_val = diag_r;
        end else if (ARADDR_IN == HIT_STATUS_OFFS) begin
            rd_val = hit_status_r;
        end else if (ARADDR_IN == MODE_CTRL_OFFS) begin
            rd_val[MODE_DNET_BIT] = mode_dnet_r;
        end else if (bank_hit(ARADDR_IN, FLTCON_BASE, NUM_FLTCON)) begin
            for (int k = 0; k < 4; k++) begin
                rd_val[k*8 +: 8] = fltcon_r[con_slot(ARADDR_IN, k)];
            end
        end else if (bank_hit(ARADDR_IN, FLTOBJ_BASE, NUM_FILTERS)) begin
            rd_val = fltobj_r[bank_idx(ARADDR_IN, FLTOBJ_BASE)];
        end else if (bank_hit(ARADDR_IN, MASK_BASE, NUM_FILTERS)) begin
            rd_val = mask_r[bank_idx(ARADDR_IN, MASK_BASE)];
        end else begin
            rd_ok = 1'b0;
        end
    end

    // Read response, one cycle after the address is taken
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RVALID_OUT <= 1'b0;
            RDATA_OUT <= '0;
            RRESP_OUT <= 2'b00;
        end else if (ARVALID_IN && ARREADY_OUT) begin
            RVALID_OUT <= 1'b1;
            RDATA_OUT <= rd_val;
            RRESP_OUT <= rd_ok ? 2'b00 : 2'b10;
        end else if (RREADY_IN) begin
            RVALID_OUT <= 1'b0;
        end
    end

    // Filter configuration registers; edits to a live filter are the
    // software's fault, so the hardware stores them but they take effect at once
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            mode_dnet_r <= 1'b0;
            for (int i = 0; i < NUM_FILTERS; i++) begin
                fltcon_r[i] <= '0;
                fltobj_r[i] <= '0;
                mask_r[i] <= '0;
            end
        end else if (wr_go && wr_ok) begin
            if (aw_addr_r == MODE_CTRL_OFFS && w_strb_r[0]) begin
                mode_dnet_r <= w_data_r[MODE_DNET_BIT];
            end
            if (bank_hit(aw_addr_r, FLTCON_BASE, NUM_FLTCON)) begin
                for (int k = 0; k < 4; k++) begin
                    if (w_strb_r[k]) begin // see R15
                        fltcon_r[con_slot(aw_addr_r, k)] <= w_data_r[k*8 +: 8]
                            & FLTCON_BYTE_MASK;
                    end
                end
            end
            if (bank_hit(aw_addr_r, FLTOBJ_BASE, NUM_FILTERS)) begin
                fltobj_r[bank_idx(aw_addr_r, FLTOBJ_BASE)] <= OBJ_MASK & lane_merge(
                    fltobj_r[bank_idx(aw_addr_r, FLTOBJ_BASE)], w_data_r, w_strb_r); // see R21
            end
            if (bank_hit(aw_addr_r, MASK_BASE, NUM_FILTERS)) begin
                mask_r[bank_idx(aw_addr_r, MASK_BASE)] <= OBJ_MASK & lane_merge(
                    mask_r[bank_idx(aw_addr_r, MASK_BASE)], w_data_r, w_strb_r);
            end
        end
    end

    // Recovery mark: a reported run of recessive bits long enough to count
    logic rec_mark;
    assign rec_mark = RECOVERY_ACTIVE_IN && ERR_EVT_IN.valid
        && ERR_EVT_IN.kind == CFDF_ERR_BIT0 && ERR_EVT_IN.run_len >= 6'(RECOVERY_RUN_BITS);

    // Error events sorted to their flag; rate picks the half, except ack which is always nominal
    logic [31:0] diag_set;
    logic [31:0] diag_wr;
    always_comb begin
        diag_set = '0;
        if (ERR_EVT_IN.valid) begin
            unique case (ERR_EVT_IN.kind)
                CFDF_ERR_CRC: diag_set[ERR_EVT_IN.data_rate ? DIAG_D_CRC : DIAG_N_CRC] = 1'b1; // see R03, R04
                CFDF_ERR_STUFF: diag_set[ERR_EVT_IN.data_rate ? DIAG_D_STUFF : DIAG_N_STUFF]
                    = (ERR_EVT_IN.run_len > 6'(STUFF_LIMIT)); // see R05
                CFDF_ERR_FORM: diag_set[ERR_EVT_IN.data_rate ? DIAG_D_FORM : DIAG_N_FORM] = 1'b1; // see R06
                CFDF_ERR_ACK: diag_set[DIAG_N_ACK] = 1'b1; // see R11
                CFDF_ERR_BIT1: diag_set[ERR_EVT_IN.data_rate ? DIAG_D_BIT1 : DIAG_N_BIT1] = 1'b1; // see R07, R13
                CFDF_ERR_BIT0: diag_set[ERR_EVT_IN.data_rate ? DIAG_D_BIT0 : DIAG_N_BIT0]
                    = !RECOVERY_ACTIVE_IN || rec_mark; // see R08, R09, R12
                default: diag_set = '0;
            endcase
        end
        if (FRAME_DONE_IN && FRAME_DLC_BYTES_IN > PAYLOAD_SIZE_IN) begin
            diag_set[DIAG_LEN_MISMATCH] = 1'b1; // see R01
        end
        if (FRAME_DONE_IN && FD_FRAME_IN && ESI_BIT_IN) begin
            diag_set[DIAG_ESI] = 1'b1; // see R02
        end
        if (BUS_OFF_RECOVERED_IN) begin
            diag_set[DIAG_BUS_OFF] = 1'b1; // see R10
        end
        diag_wr = lane_merge(diag_r, w_data_r, w_strb_r);
    end

    // Diagnostic register: hardware set wins over a software write
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            diag_r <= DIAG_RESET;
        end else begin
            if (wr_go && aw_addr_r == DIAG_OFFS) begin
                diag_r[31:16] <= (diag_wr[31:16] & DIAG_FLAG_MASK[31:16]) | diag_set[31:16];
            end else begin
                diag_r[31:16] <= diag_r[31:16] | diag_set[31:16]; // see R09
            end
            if (FRAME_OK_IN) begin
                diag_r[15:0] <= diag_r[15:0] + 16'h0001; // see R14
            end else if (wr_go && aw_addr_r == DIAG_OFFS) begin
                diag_r[15:0] <= diag_wr[15:0];
            end
        end
    end

    // Per-filter match: mask-one bits only, type rule, alternate mode
    logic [NUM_FILTERS-1:0] match;
    always_comb begin
        logic [17:0] eid_cmp;
        eid_cmp = mode_dnet_r ? {FRAME_IN.data01, 2'b00} : FRAME_IN.extended_id_pattern; // see R22
        for (int i = 0; i < NUM_FILTERS; i++) begin
            logic id_eq;
            logic type_ok;
            id_eq = (((FRAME_IN.standard_id_pattern ^ fltobj_r[i][OBJ_SID_MSB:0])
                & mask_r[i][OBJ_SID_MSB:0]) == '0) // see R24
                && !((FRAME_IN.sid_x ^ fltobj_r[i][OBJ_SID_X_BIT]) & mask_r[i][OBJ_SID_X_BIT]);
            if (FRAME_IN.ext || mode_dnet_r) begin
                id_eq = id_eq && (((eid_cmp ^ fltobj_r[i][OBJ_EID_MSB:OBJ_EID_LSB])
                    & mask_r[i][OBJ_EID_MSB:OBJ_EID_LSB]) == '0);
            end
            type_ok = !mask_r[i][OBJ_EXT_SEL_BIT] // see R23
                || (fltobj_r[i][OBJ_EXT_SEL_BIT] == FRAME_IN.ext); // see R20
            match[i] = fltcon_r[i][FLTCON_EN_BIT] && id_eq && type_ok; // see R15
        end
    end

    // Lowest matching filter wins; pointer zero never steers a frame
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            HIT_VALID_OUT <= 1'b0;
            HIT_OUT <= 1'b0;
            HIT_OBJECT_OUT <= '0;
            HIT_FILTER_OUT <= '0;
            hit_status_r <= '0;
        end else begin
            HIT_VALID_OUT <= FRAME_IN.valid;
            if (FRAME_IN.valid) begin
                HIT_OUT <= 1'b0;
                HIT_OBJECT_OUT <= '0;
                HIT_FILTER_OUT <= '0;
                hit_status_r <= '0;
                for (int i = NUM_FILTERS - 1; i >= 0; i--) begin
                    if (match[i] && fltcon_r[i][OBJ_PTR_W-1:0] != '0) begin // see R17
                        HIT_OUT <= 1'b1;
                        HIT_OBJECT_OUT <= fltcon_r[i][OBJ_PTR_W-1:0]; // see R16
                        HIT_FILTER_OUT <= FLT_IDX_W'(i);
                        hit_status_r <= {23'h000000, 1'b1, 3'h0,
                            fltcon_r[i][OBJ_PTR_W-1:0]}; // Hit of the latest frame, for software; a miss clears it
                    end
                end
            end
        end
    end

endmodule

// File: verification/cfdf_diag_filter_checker.sv
// Port assertions for the diagnostic and filter block
`timescale 1ns/1ps
module cfdf_diag_filter_checker
    import cfdf_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    // Register bus answers
    input wire logic BVALID_OUT,
    input wire logic BREADY_IN,
    input wire logic [1:0] BRESP_OUT,
    input wire logic ARVALID_IN,
    input wire logic ARREADY_OUT,
    input wire logic RVALID_OUT,
    input wire logic RREADY_IN,
    input wire logic [31:0] RDATA_OUT,
    // Filter request and answer
    input wire cfdf_frame_t FRAME_IN,
    input wire logic HIT_VALID_OUT,
    input wire logic HIT_OUT,
    input wire logic [OBJ_PTR_W-1:0] HIT_OBJECT_OUT
);
    default clocking @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // Read steps: request taken, then answer waiting on the master
    sequence s_read_taken;
        ARVALID_IN && ARREADY_OUT;
    endsequence
    sequence s_read_waits;
        RVALID_OUT && !RREADY_IN;
    endsequence
    a_read_answer: assert property (s_read_taken |=> RVALID_OUT)
        else $error("read answer late");
    a_read_holds: assert property (s_read_waits |=> RVALID_OUT && $stable(RDATA_OUT))
        else $error("read data not held");
    a_write_holds: assert property (BVALID_OUT && !BREADY_IN |=> BVALID_OUT && $stable(BRESP_OUT))
        else $error("write answer not held");
    a_read_refused: assert property (RVALID_OUT |-> !ARREADY_OUT)
        else $error("read taken while answer pending");
    a_hit_timing: assert property (FRAME_IN.valid |=> HIT_VALID_OUT)
        else $error("filter answer late");
    a_hit_single: assert property (!FRAME_IN.valid |=> !HIT_VALID_OUT)
        else $error("filter answer without request");
    a_hit_object: assert property (HIT_VALID_OUT && HIT_OUT |-> HIT_OBJECT_OUT != '0)
        else $error("hit names object zero");
    a_hit_held: assert property (!HIT_VALID_OUT |-> $stable(HIT_OUT) && $stable(HIT_OBJECT_OUT))
        else $error("filter answer changed between requests");
endmodule

// File: verification/cfdf_engine_model.sv
// Behavioural protocol engine that feeds error and frame events
`timescale 1ns/1ps
module cfdf_engine_model
    import cfdf_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Events towards the block
    output cfdf_err_evt_t err_evt_out,
    output logic ok_out,
    output logic done_out,
    output logic [6:0] dlc_out,
    output logic [6:0] psize_out,
    output logic fd_out,
    output logic esi_out,
    output logic boff_out,
    output logic rec_out
);
    // Quiet between events
    initial begin
        err_evt_out = '0;
        {ok_out, done_out, dlc_out, psize_out, fd_out, esi_out, boff_out, rec_out} = '0;
    end
    // One-cycle error report; the rate bit names the phase of the bad bit
    task automatic err(input cfdf_err_kind_t k, input logic dr, input logic [5:0] rl);
        @(posedge clk_in);
        err_evt_out <= '{1'b1, k, dr, rl};
        @(posedge clk_in);
        err_evt_out <= '0;
    endtask
    // Frame end with its length and indicator bits
    task automatic frame(input logic [6:0] dl, input logic [6:0] ps, input logic f, input logic e);
        @(posedge clk_in);
        {done_out, dlc_out, psize_out, fd_out, esi_out} <= {1'b1, dl, ps, f, e};
        @(posedge clk_in);
        done_out <= 1'b0;
    endtask
    // Pulse: 0 error-free frame, 1 bus-off recovered
    task automatic pulse(input logic sel);
        @(posedge clk_in);
        {boff_out, ok_out} <= sel ? 2'b10 : 2'b01;
        @(posedge clk_in);
        {boff_out, ok_out} <= 2'b00;
    endtask
    // Recovery level, held while the bus-off wait runs
    task automatic recover(input logic v);
        @(posedge clk_in);
        rec_out <= v;
    endtask
endmodule

// File: verification/cfdf_diag_filter_tb.sv
// Self-checking bench for the diagnostic and filter block
`timescale 1ns/1ps
module cfdf_diag_filter_tb
    import cfdf_pkg::*;
;
    logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
    logic arready, rvalid, hit_valid, hit, ok, done, fd, esi, boff, rec;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp, rd_resp, wr_resp;
    logic [3:0] wstrb, hit_flt;
    logic [4:0] hit_obj;
    logic [6:0] dlc, psize;
    cfdf_frame_t frame_r;
    cfdf_err_evt_t err_evt;
    int fails = 0, tests_run = 0, cyc = 0;
    int pos[2][6] = '{'{21, 20, 19, 18, 17, 16}, '{29, 28, 27, 0, 25, 24}};

    cfdf_diag_filter u_dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .AWADDR_IN(awaddr), .AWVALID_IN(awvalid),
        .AWREADY_OUT(awready), .WDATA_IN(wdata), .WSTRB_IN(wstrb), .WVALID_IN(wvalid),
        .WREADY_OUT(wready), .BRESP_OUT(bresp), .BVALID_OUT(bvalid), .BREADY_IN(bready),
        .ARADDR_IN(araddr), .ARVALID_IN(arvalid), .ARREADY_OUT(arready), .RDATA_OUT(rdata),
        .RRESP_OUT(rresp), .RVALID_OUT(rvalid), .RREADY_IN(rready), .ERR_EVT_IN(err_evt),
        .FRAME_OK_IN(ok), .FRAME_DONE_IN(done), .FRAME_DLC_BYTES_IN(dlc),
        .PAYLOAD_SIZE_IN(psize), .FD_FRAME_IN(fd), .ESI_BIT_IN(esi),
        .BUS_OFF_RECOVERED_IN(boff), .RECOVERY_ACTIVE_IN(rec), .FRAME_IN(frame_r),
        .HIT_VALID_OUT(hit_valid), .HIT_OUT(hit), .HIT_OBJECT_OUT(hit_obj),
        .HIT_FILTER_OUT(hit_flt)
    );
    cfdf_engine_model u_eng (
        .clk_in(clk), .err_evt_out(err_evt), .ok_out(ok), .done_out(done), .dlc_out(dlc),
        .psize_out(psize), .fd_out(fd), .esi_out(esi), .boff_out(boff), .rec_out(rec)
    );

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Hang guard, far beyond the few hundred cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            $display("[FAIL] %0t cyc %h lim %h", $time, cyc, 20000);
            test_done();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Write; ready raised on the second edge, the same edge the answer appears, so the slave never holds it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hf};
        {awvalid, wvalid} <= 2'b11;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n == 2) bready <= 1'b1;
        end while (!(bvalid && bready));
        bready <= 1'b0;
        wr_resp = bresp;
    endtask
    // Read and compare the data taken at the answering edge
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        int n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n == 2) rready <= 1'b1;
        end while (!(rvalid && rready));
        rready <= 1'b0;
        rd_resp = rresp;
        chk(rdata, e);
    endtask
    // One frame; the answer is looked at just after the taking edge
    task automatic filt(input logic e, input logic [10:0] s, input logic [15:0] d,
                        input logic h, input logic [4:0] o, input logic [3:0] f);
        @(posedge clk);
        frame_r <= '{1'b1, e, s, 1'b0, 18'h0, d};
        @(posedge clk);
        frame_r.valid <= 1'b0;
        #1;
        if (h) chk(32'({hit_valid, hit, hit_obj, hit_flt}), 32'({1'b1, h, o, f}));
        else chk(32'({hit_valid, hit}), 32'h2);
    endtask
    task automatic test_done();
        if (fails == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        frame_r = '0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(DIAG_OFFS, 32'h0);
        rd(FLTCON_BASE, 32'h0);
        // Every error kind on each phase; the data phase has no ack flag
        for (int k = 0; k < 6; k++) begin
            for (int r = 0; r < 2; r++) begin
                if (k == 3 && r == 1) continue;
                wr(DIAG_OFFS, 32'h0);
                u_eng.err(cfdf_err_kind_t'(k), r[0], 6'h06);
                rd(DIAG_OFFS, 32'h1 << pos[r][k]);
            end
        end
        wr(DIAG_OFFS, 32'h0);
        u_eng.err(CFDF_ERR_STUFF, 1'b0, 6'h05);
        rd(DIAG_OFFS, 32'h0);
        u_eng.recover(1'b1);
        u_eng.err(CFDF_ERR_BIT0, 1'b0, 6'h0a);
        rd(DIAG_OFFS, 32'h0);
        u_eng.err(CFDF_ERR_BIT0, 1'b0, 6'h0b);
        u_eng.recover(1'b0);
        rd(DIAG_OFFS, 32'h00010000);
        wr(DIAG_OFFS, 32'h0);
        u_eng.pulse(1'b1);
        rd(DIAG_OFFS, 32'h00800000);
        // Length above payload size, then equal length with indicator set
        wr(DIAG_OFFS, 32'h0);
        u_eng.frame(7'h40, 7'h20, 1'b1, 1'b0);
        rd(DIAG_OFFS, 32'h80000000);
        wr(DIAG_OFFS, 32'h0);
        u_eng.frame(7'h20, 7'h20, 1'b1, 1'b1);
        rd(DIAG_OFFS, 32'h40000000);
        // Counter wraps at sixteen bits
        wr(DIAG_OFFS, 32'h0000fffe);
        repeat (3) u_eng.pulse(1'b0);
        rd(DIAG_OFFS, 32'h00000001);
        wr(DIAG_OFFS, 32'hffffffff);
        rd(DIAG_OFFS, 32'hfbbfffff);
        // Last control register, then the first address past it
        wr(FLTCON_BASE + 8'h0c, 32'hffffffff);
        rd(FLTCON_BASE + 8'h0c, 32'h9f9f9f9f);
        wr(FLTCON_BASE + 8'h0c, 32'h1f1f1f1f);
        wr(FLTCON_BASE + 8'h10, 32'h0);
        chk(32'(wr_resp), 32'h2);
        rd(FLTCON_BASE + 8'h10, 32'h0);
        chk(32'(rd_resp), 32'h2);
        // Each enable position, masks left all don't-care
        for (int k = 0; k < 4; k++) begin
            wr(FLTCON_BASE, 32'(8'h80 | 8'(31 - k)) << (8 * k));
            filt(1'b0, 11'h555, 16'h0, 1'b1, 5'(31 - k), 4'(k));
            wr(FLTCON_BASE, 32'(8'(31 - k)) << (8 * k));
        end
        filt(1'b0, 11'h555, 16'h0, 1'b0, 5'h0, 4'h0);
        wr(MASK_BASE, 32'h400007ff);
        wr(FLTOBJ_BASE, 32'h00000123);
        wr(FLTCON_BASE, 32'h00000085);
        filt(1'b0, 11'h123, 16'h0, 1'b1, 5'h05, 4'h0);
        filt(1'b0, 11'h124, 16'h0, 1'b0, 5'h0, 4'h0);
        filt(1'b1, 11'h123, 16'h0, 1'b0, 5'h0, 4'h0);
        wr(FLTCON_BASE, 32'h00000005);
        wr(MASK_BASE, 32'h000007ff);
        wr(FLTCON_BASE, 32'h00000085);
        filt(1'b1, 11'h123, 16'h0, 1'b1, 5'h05, 4'h0);
        // Alternate mode matches the first two data bytes
        wr(FLTCON_BASE, 32'h00000005);
        wr(MODE_CTRL_OFFS, 32'h1);
        wr(MASK_BASE, 32'h1fffffff);
        wr(FLTOBJ_BASE, 32'h17dde123);
        wr(FLTCON_BASE, 32'h00000085);
        filt(1'b0, 11'h123, 16'hbeef, 1'b1, 5'h05, 4'h0);
        rd(HIT_STATUS_OFFS, 32'h00000105);
        filt(1'b0, 11'h123, 16'hbeee, 1'b0, 5'h0, 4'h0);
        test_done();
    end
endmodule

bind cfdf_diag_filter cfdf_diag_filter_checker u_chk (
    .CLK_SYS_IN, .RST_N_IN, .BVALID_OUT, .BREADY_IN, .BRESP_OUT, .ARVALID_IN,
    .ARREADY_OUT, .RVALID_OUT, .RREADY_IN, .RDATA_OUT, .FRAME_IN, .HIT_VALID_OUT,
    .HIT_OUT, .HIT_OBJECT_OUT
);
